// ### verilog/fcr_pkg.sv
// Constants for the FIFO / channel / slot router.
// Assumes an 8-bit register port and byte-wide slot and FIFO data.
package fcr_pkg;
	// Register addresses
	localparam logic [7:0] A_MODE = 8'h0D;
	localparam logic [7:0] A_FSEL = 8'h0F;
	localparam logic [7:0] A_SSEL = 8'h10;
	localparam logic [7:0] A_STAT = 8'h11;
	localparam logic [7:0] A_SLCFG = 8'hD0;
	localparam logic [7:0] A_MSK = 8'hF4;
	localparam logic [7:0] A_FCTL = 8'hFA;
	localparam logic [7:0] A_FILL = 8'hFB;
	localparam logic [7:0] A_ASG = 8'hFC;
	// Field positions
	localparam int FS_DIR = 0;
	localparam int FS_NUM = 1;
	localparam int FS_REV = 7;
	localparam int SS_DIR = 0;
	localparam int SS_NUM = 1;
	localparam int SC_DIR = 0;
	localparam int SC_NUM = 1;
	localparam int SC_RT = 6;
	localparam int AS_DIR = 0;
	localparam int AS_NUM = 1;
	localparam int FC_IFF = 0;
	localparam int FC_TRP = 1;
	localparam int FC_IRQ = 2;
	localparam int IRQ_W = 3;
	localparam int STAT_BUSY = 7;
	// Codes
	localparam logic [1:0] DF_CSM = 2'h1;
	localparam logic [1:0] RT_ONE = 2'h2;
	localparam logic [1:0] RT_TWO = 2'h3;
	// Reset and fill values
	localparam logic [7:0] IFF_FLAG = 8'h7E;
	localparam logic [7:0] IFF_ONES = 8'hFF;
	localparam logic [7:0] FILL_RST = 8'hFF;
	localparam logic [7:0] MSK_RST = 8'hFF;
	localparam logic [7:0] RD_NONE = 8'h00;
	localparam logic [4:0] BYTE_BITS = 5'h08;
	// Timing
	localparam int FRAME_NS = 125000;
	localparam int CLK_NS = 4;
endpackage

// ### verilog/fcr_router.sv
// What this block does
// - PCM-to-PCM path uses channel store only
// - Two slots on one channel loop data
// - Fixed mode: FIFO n uses channel n
// - Mode field value 01 selects channel-select
// - Per-FIFO registers indexed by FIFO select
// - Channel-select: any FIFO to any channel
// - Several FIFOs may share one channel
// - Per-FIFO channel number and direction register
// - Slot-to-line path needs one enabled FIFO
// - Shared byte built from each FIFO's bits
// - Uncontributed bits taken from fill byte
// - Transparent FIFO moves one byte per frame
// - Framed FIFO rate follows contributed bit count
// - FIFO carries data only when enable nonzero
// - Optional reversed bit order per FIFO
// - Periodic event per transparent FIFO; end-of-frame event on transmit FIFOs only
// - Fill 0x7E between frames when cleared
// - Routing codes 10 and 11 pick lines
// Holds all router logic; outside FIFO memory answers within the cycle.
`timescale 1ns/1ns
module fcr_router #(
	parameter int NFIFO = 16,
	parameter int NSLOT = 32,
	parameter int NLINE = 4
) (
	input wire logic i_clk, // 250 MHz
	input wire logic i_resetn, // Async reset
	input wire logic [7:0] i_addr, // Register address
	input wire logic [7:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [7:0] o_rdata, // Read data, next cycle
	input wire logic [7:0] i_pcm_line_one, // Line one in
	output logic [7:0] o_pcm_line_one, // Line one out
	output logic o_pcm_line_one_oe, // Line one drive
	input wire logic [7:0] i_pcm_line_two, // Line two in
	output logic [7:0] o_pcm_line_two, // Line two out
	output logic o_pcm_line_two_oe, // Line two drive
	input wire logic [NLINE-1:0][7:0] i_line_rx, // Line chan in
	output logic [NLINE-1:0][7:0] o_line_tx, // Line chan out
	output logic [NLINE-1:0] o_line_tx_en, // Line chan live
	output logic o_fifo_tx_req, // Fetch byte
	output logic [$clog2(NFIFO):0] o_fifo_id, // {dir,num}
	input wire logic [7:0] i_fifo_tx_data, // Fetched byte
	input wire logic i_fifo_tx_avail, // Frame data ready
	input wire logic i_fifo_tx_last, // Last of frame
	output logic o_fifo_rx_valid, // Rx byte pulse
	output logic [7:0] o_fifo_rx_data, // Rx byte
	output logic [$clog2(NFIFO):0] o_fifo_rx_id, // Rx FIFO
	output logic o_fifo_event, // Event pulse
	output logic [$clog2(NFIFO):0] o_fifo_event_id // Event FIFO
);
	localparam int FW = $clog2(NFIFO);
	localparam int SW = $clog2(NSLOT);
	localparam int SLOT_CYC = fcr_pkg::FRAME_NS /
		(fcr_pkg::CLK_NS * NSLOT);
	localparam int DW = $clog2(SLOT_CYC);
	localparam logic [DW-1:0] DIV_END = DW'(SLOT_CYC - 1);
	localparam logic [FW:0] IDX_END = '1;

	typedef struct packed {
		logic [1:0] mode;
		logic [7:0] fsel, ssel, rd;
		logic [2*NFIFO-1:0][4:0] asg, fctl, cred;
		logic [2*NFIFO-1:0][7:0] fill, msk, st;
		logic [2*NFIFO-1:0] rev, tch, len;
		logic [2*NSLOT-1:0][7:0] slot;
		logic [DW-1:0] div;
		logic [SW-1:0] sl;
		logic busy, oe1, oe2, rxv, evt;
		logic [FW:0] idx, rxid, evid;
		logic [7:0] p1a, p1b, p2a, p2b, o1, o2, rxd;
		logic [NLINE-1:0][7:0] ltx;
		logic [NLINE-1:0] lten;
	} fcr_state_t;

	fcr_state_t r;
	fcr_state_t next_r;

	function automatic logic [7:0] fcr_rev(input logic [7:0] b);
		logic [7:0] o;
		o = '0;
		for (int i = 0; i < 8; i++) begin
			o[i] = b[7-i];
		end
		return o;
	endfunction

	function automatic logic [4:0] fcr_pop(input logic [7:0] b);
		logic [4:0] c;
		c = '0;
		for (int i = 0; i < 8; i++) begin
			c = c + 5'(b[i]);
		end
		return c;
	endfunction

	logic tick, channel_select_mode, en, trp, evt_en, move;
	logic [FW:0] fk, k, ch;
	logic [SW:0] si;
	logic [4:0] fl, cr;
	logic [7:0] dat, base, rsc, tsc, rxb;

	always_comb begin
		next_r = r;
		tick = (r.div == DIV_END);
		channel_select_mode = (r.mode == fcr_pkg::DF_CSM);
		fk = {r.fsel[fcr_pkg::FS_DIR], r.fsel[fcr_pkg::FS_NUM +: FW]};
		si = {r.ssel[fcr_pkg::SS_DIR], r.ssel[fcr_pkg::SS_NUM +: SW]};
		k = r.idx;
		fl = r.fctl[k];
		en = (fl[fcr_pkg::FC_IRQ +: fcr_pkg::IRQ_W] != '0);
		// Value 1 only enables; higher values also raise events
		evt_en = (fl[fcr_pkg::FC_IRQ +: fcr_pkg::IRQ_W] > 3'h1);
		trp = fl[fcr_pkg::FC_TRP];
		if (channel_select_mode) begin
			ch = {r.asg[k][fcr_pkg::AS_DIR],
				r.asg[k][fcr_pkg::AS_NUM +: FW]};
		end else begin
			ch = k;
		end
		cr = r.cred[k] + fcr_pop(r.msk[k]);
		move = trp || (cr >= fcr_pkg::BYTE_BITS);
		o_fifo_tx_req = r.busy && !k[FW] && en && move &&
			(trp || i_fifo_tx_avail);
		o_fifo_id = k;
		if (o_fifo_tx_req) begin
			dat = r.rev[k] ? fcr_rev(i_fifo_tx_data) :
				i_fifo_tx_data;
		end else if (fl[fcr_pkg::FC_IFF]) begin
			dat = fcr_pkg::IFF_ONES;
		end else begin
			dat = fcr_pkg::IFF_FLAG;
		end
		base = r.tch[ch] ? r.st[ch] : r.fill[k];
		rxb = r.st[ch] & r.msk[k];
		rsc = r.slot[{1'b1, r.sl}];
		tsc = r.slot[{1'b0, r.sl}];
		next_r.p1a = i_pcm_line_one;
		next_r.p1b = r.p1a;
		next_r.p2a = i_pcm_line_two;
		next_r.p2b = r.p2a;
		next_r.rd = fcr_pkg::RD_NONE;
		next_r.rxv = 1'b0;
		next_r.evt = 1'b0;
		next_r.div = tick ? '0 : r.div + 1'b1;

		if (i_wr) begin
			case (i_addr)
				fcr_pkg::A_MODE: begin
					next_r.mode = i_wdata[1:0];
				end
				fcr_pkg::A_FSEL: begin
					next_r.fsel = i_wdata;
					next_r.rev[{i_wdata[fcr_pkg::FS_DIR],
						i_wdata[fcr_pkg::FS_NUM +: FW]}] =
						i_wdata[fcr_pkg::FS_REV];
				end
				fcr_pkg::A_SSEL: begin
					next_r.ssel = i_wdata;
				end
				fcr_pkg::A_SLCFG: begin
					next_r.slot[si] = i_wdata;
				end
				fcr_pkg::A_MSK: begin
					next_r.msk[fk] = i_wdata;
				end
				fcr_pkg::A_FCTL: begin
					next_r.fctl[fk] = i_wdata[4:0];
				end
				fcr_pkg::A_FILL: begin
					next_r.fill[fk] = i_wdata;
				end
				fcr_pkg::A_ASG: begin
					next_r.asg[fk] = i_wdata[4:0];
				end
				default: begin
				end
			endcase
		end

		if (i_rd) begin
			case (i_addr)
				fcr_pkg::A_MODE: next_r.rd = 8'(r.mode);
				fcr_pkg::A_FSEL: next_r.rd = r.fsel;
				fcr_pkg::A_SSEL: next_r.rd = r.ssel;
				fcr_pkg::A_SLCFG: next_r.rd = r.slot[si];
				fcr_pkg::A_MSK: next_r.rd = r.msk[fk];
				fcr_pkg::A_FCTL: next_r.rd = 8'(r.fctl[fk]);
				fcr_pkg::A_FILL: next_r.rd = r.fill[fk];
				fcr_pkg::A_ASG: next_r.rd = 8'(r.asg[fk]);
				fcr_pkg::A_STAT: begin
					next_r.rd = 8'(r.sl);
					next_r.rd[fcr_pkg::STAT_BUSY] = r.busy;
				end
				default: next_r.rd = fcr_pkg::RD_NONE;
			endcase
		end

		// Slot side never touches a FIFO
		if (tick) begin
			next_r.sl = r.sl + 1'b1;
			next_r.oe1 = 1'b0;
			next_r.oe2 = 1'b0;
			if (rsc[fcr_pkg::SC_RT +: 2] == fcr_pkg::RT_ONE) begin
				next_r.st[{rsc[fcr_pkg::SC_DIR],
					rsc[fcr_pkg::SC_NUM +: FW]}] = r.p2b;
			end else if (rsc[fcr_pkg::SC_RT +: 2] == fcr_pkg::RT_TWO)
			begin
				next_r.st[{rsc[fcr_pkg::SC_DIR],
					rsc[fcr_pkg::SC_NUM +: FW]}] = r.p1b;
			end
			if (tsc[fcr_pkg::SC_RT +: 2] == fcr_pkg::RT_ONE) begin
				next_r.oe1 = 1'b1;
				next_r.o1 = r.st[{tsc[fcr_pkg::SC_DIR],
					tsc[fcr_pkg::SC_NUM +: FW]}];
			end else if (tsc[fcr_pkg::SC_RT +: 2] == fcr_pkg::RT_TWO)
			begin
				next_r.oe2 = 1'b1;
				next_r.o2 = r.st[{tsc[fcr_pkg::SC_DIR],
					tsc[fcr_pkg::SC_NUM +: FW]}];
			end
			if (r.sl == '0) begin
				// Line channels follow last frame's FIFO enables
				for (int c = 0; c < NLINE; c++) begin
					next_r.lten[c] = r.len[c];
					next_r.ltx[c] = r.len[c] ? r.st[c] :
						fcr_pkg::IFF_ONES;
					if (r.len[NFIFO+c]) begin
						next_r.st[NFIFO+c] = i_line_rx[c];
					end
				end
				next_r.len = '0;
				next_r.tch = '0;
				next_r.busy = 1'b1;
				next_r.idx = '0;
			end
		end

		// One FIFO per cycle; SLOT_CYC exceeds the pass length
		if (r.busy) begin
			next_r.idx = k + 1'b1;
			if (k == IDX_END) begin
				next_r.busy = 1'b0;
			end
			if (en) begin
				next_r.len[ch] = 1'b1;
				if (trp) begin
					next_r.cred[k] = '0;
				end else if (move) begin
					next_r.cred[k] = cr - fcr_pkg::BYTE_BITS;
				end else begin
					next_r.cred[k] = cr;
				end
				if (!k[FW]) begin
					next_r.st[ch] = (base & ~r.msk[k]) |
						(dat & r.msk[k]);
					next_r.tch[ch] = 1'b1;
					if (evt_en && (trp ? move :
						(o_fifo_tx_req && i_fifo_tx_last))) begin
						next_r.evt = 1'b1;
						next_r.evid = k;
					end
				end else if (move) begin
					next_r.rxv = 1'b1;
					next_r.rxd = r.rev[k] ? fcr_rev(rxb) : rxb;
					next_r.rxid = k;
					if (evt_en && trp) begin
						next_r.evt = 1'b1;
						next_r.evid = k;
					end
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '0;
			r.fill <= {(2*NFIFO){fcr_pkg::FILL_RST}};
			r.msk <= {(2*NFIFO){fcr_pkg::MSK_RST}};
		end else begin
			r <= next_r;
		end
	end

	assign o_rdata = r.rd;
	assign o_pcm_line_one = r.o1;
	assign o_pcm_line_one_oe = r.oe1;
	assign o_pcm_line_two = r.o2;
	assign o_pcm_line_two_oe = r.oe2;
	assign o_line_tx = r.ltx;
	assign o_line_tx_en = r.lten;
	assign o_fifo_rx_valid = r.rxv;
	assign o_fifo_rx_data = r.rxd;
	assign o_fifo_rx_id = r.rxid;
	assign o_fifo_event = r.evt;
	assign o_fifo_event_id = r.evid;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	property p_loop;
		tick && rsc[fcr_pkg::SC_RT +: 2] == fcr_pkg::RT_TWO |=>
			r.st[$past(rsc[fcr_pkg::SC_NUM +: FW]) +
			(NFIFO * $past(rsc[fcr_pkg::SC_DIR]))] == $past(r.p1b);
	endproperty
	a_loop: assert property (p_loop)
		else $error("slot byte not stored in channel");

	property p_fixed;
		r.busy && !channel_select_mode |-> ch == k;
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed mode channel differs from FIFO");

	property p_csm;
		r.busy && channel_select_mode |-> ch[FW-1:0] ==
			r.asg[k][fcr_pkg::AS_NUM +: FW];
	endproperty
	a_csm: assert property (p_csm)
		else $error("assigned channel not used");

	property p_en;
		o_fifo_tx_req |-> en && r.busy;
	endproperty
	a_en: assert property (p_en)
		else $error("disabled FIFO fetched");

	property p_iff;
		r.busy && !k[FW] && en && !trp && !fl[fcr_pkg::FC_IFF] &&
			!o_fifo_tx_req && r.msk[k] == fcr_pkg::MSK_RST |=>
			r.st[$past(ch)] == fcr_pkg::IFF_FLAG;
	endproperty
	a_iff: assert property (p_iff)
		else $error("inter-frame fill not sent");

	property p_route;
		tick && tsc[fcr_pkg::SC_RT +: 2] == fcr_pkg::RT_ONE |=>
			o_pcm_line_one_oe && !o_pcm_line_two_oe;
	endproperty
	a_route: assert property (p_route)
		else $error("transmit slot on wrong line");

	property p_trp;
		r.busy && k[FW] && en && trp |=> o_fifo_rx_valid &&
			o_fifo_rx_id == $past(k);
	endproperty
	a_trp: assert property (p_trp)
		else $error("transparent receive byte missing");

	property p_rd;
		i_rd && i_addr == fcr_pkg::A_FSEL |=> o_rdata == $past(r.fsel)
			##1 o_rdata == fcr_pkg::RD_NONE || $past(i_rd);
	endproperty
	a_rd: assert property (p_rd)
		else $error("select register read wrong");

	property p_line;
		tick && r.sl == '0 |=> o_line_tx_en == $past(r.len[NLINE-1:0]);
	endproperty
	a_line: assert property (p_line)
		else $error("line channel enable not from FIFO");
endmodule

// ### testbench/fcr_far_model.sv
// Far side of the router: PCM line pair, line channels and FIFO memory.
// Assumes one clock shared with the router; counts traffic since the last clear.
`timescale 1ns/1ns
module fcr_far_model (
	input wire logic i_clk, // Router clock
	input wire logic i_clear, // Restart counters
	input wire logic [7:0] i_dev_one, // Router line one out
	input wire logic i_dev_one_oe, // Router drives line one
	output logic [7:0] o_line_one, // Line one level
	input wire logic [7:0] i_dev_two, // Router line two out
	input wire logic i_dev_two_oe, // Router drives line two
	output logic [7:0] o_line_two, // Line two level
	output logic [3:0][7:0] o_line_rx, // Line channel bytes
	input wire logic i_fifo_req, // Byte fetch
	input wire logic [4:0] i_fifo_id, // Serviced FIFO
	output logic [7:0] o_fifo_data, // Fetched byte
	output logic o_fifo_avail, // Framed data ready
	output logic o_fifo_last, // Frame end
	input wire logic i_rx_valid, // Received byte pulse
	input wire logic [7:0] i_rx_data, // Received byte
	input wire logic [4:0] i_rx_id // Received FIFO
);
	int req_cnt, rx_cnt, one_cnt, two_cnt;
	logic [7:0] rx_data, one_data, two_data;
	logic [4:0] rx_id;
	// Far talker owns the line whenever the router lets go
	assign o_line_one = i_dev_one_oe ? i_dev_one : 8'h69;
	assign o_line_two = i_dev_two_oe ? i_dev_two : 8'h96;
	assign o_line_rx = {8'h11, 8'h22, 8'h5C, 8'h33};
	// Byte tied to FIFO number so a wrong fetch shows
	assign o_fifo_data = {4'hA, i_fifo_id[3:0]};
	assign o_fifo_avail = 1'b0;
	assign o_fifo_last = 1'b0;
	always_ff @(posedge i_clk) begin
		if (i_clear) begin
			req_cnt <= 0;
			rx_cnt <= 0;
			one_cnt <= 0;
			two_cnt <= 0;
		end else begin
			req_cnt <= req_cnt + int'(i_fifo_req);
			rx_cnt <= rx_cnt + int'(i_rx_valid);
			one_cnt <= one_cnt + int'(i_dev_one_oe);
			two_cnt <= two_cnt + int'(i_dev_two_oe);
			if (i_rx_valid) begin
				rx_data <= i_rx_data;
				rx_id <= i_rx_id;
			end
			if (i_dev_one_oe)
				one_data <= i_dev_one;
			if (i_dev_two_oe)
				two_data <= i_dev_two;
		end
	end
endmodule

// ### testbench/fcr_router_tb.sv
// Self-checking bench for the router: registers, FIFO paths, slot loop.
// Assumes 32 slots of 976 cycles per frame and one FIFO pass per frame.
`timescale 1ns/1ns
module fcr_router_tb;
	logic i_clk, i_resetn, i_wr, i_rd, clr;
	logic [7:0] i_addr, i_wdata, o_rdata, p1, p1_o, p2, p2_o, tx_d, rx_d;
	logic p1_oe, p2_oe, tx_req, tx_av, tx_last, rx_v, ev;
	logic [3:0][7:0] l_rx, l_tx;
	logic [3:0] l_en;
	logic [4:0] f_id, rx_id, ev_id;
	int fail_count, n_tests, ev_cnt;
	localparam int FRAME = 31232;

	fcr_router u_fcr_router (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_pcm_line_one(p1), .o_pcm_line_one(p1_o),
		.o_pcm_line_one_oe(p1_oe), .i_pcm_line_two(p2),
		.o_pcm_line_two(p2_o), .o_pcm_line_two_oe(p2_oe),
		.i_line_rx(l_rx), .o_line_tx(l_tx), .o_line_tx_en(l_en),
		.o_fifo_tx_req(tx_req), .o_fifo_id(f_id), .i_fifo_tx_data(tx_d),
		.i_fifo_tx_avail(tx_av), .i_fifo_tx_last(tx_last),
		.o_fifo_rx_valid(rx_v), .o_fifo_rx_data(rx_d),
		.o_fifo_rx_id(rx_id), .o_fifo_event(ev), .o_fifo_event_id(ev_id));

	fcr_far_model u_fcr_far_model (.i_clk(i_clk), .i_clear(clr),
		.i_dev_one(p1_o), .i_dev_one_oe(p1_oe), .o_line_one(p1),
		.i_dev_two(p2_o), .i_dev_two_oe(p2_oe), .o_line_two(p2),
		.o_line_rx(l_rx), .i_fifo_req(tx_req), .i_fifo_id(f_id),
		.o_fifo_data(tx_d), .o_fifo_avail(tx_av), .o_fifo_last(tx_last),
		.i_rx_valid(rx_v), .i_rx_data(rx_d), .i_rx_id(rx_id));

	// Enable value 1 must never raise an event
	always @(posedge i_clk) begin
		if (clr)
			ev_cnt <= 0;
		else
			ev_cnt <= ev_cnt + int'(ev);
	end

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		chk(32'(o_rdata), 32'(exp));
	endtask

	task automatic complete_run;
		$display("tests %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic test_regs;
		wr(fcr_pkg::A_MODE, 8'h01);
		wr(fcr_pkg::A_FSEL, 8'h06);
		wr(fcr_pkg::A_ASG, 8'h04);
		wr(fcr_pkg::A_FCTL, 8'h06);
		wr(fcr_pkg::A_FSEL, 8'h87);
		wr(fcr_pkg::A_ASG, 8'h03);
		wr(fcr_pkg::A_FCTL, 8'h06);
		rd(fcr_pkg::A_MODE, 8'h01);
		rd(fcr_pkg::A_FSEL, 8'h87);
		rd(fcr_pkg::A_ASG, 8'h03);
		rd(fcr_pkg::A_MSK, fcr_pkg::MSK_RST);
		rd(fcr_pkg::A_FILL, fcr_pkg::FILL_RST);
		rd(8'h01, fcr_pkg::RD_NONE);
		// Loop on channel 14: slot 4 in from one, out on two and one
		wr(fcr_pkg::A_SSEL, 8'h09);
		wr(fcr_pkg::A_SLCFG, 8'hDD);
		wr(fcr_pkg::A_SSEL, 8'h0A);
		wr(fcr_pkg::A_SLCFG, 8'hDD);
		wr(fcr_pkg::A_SSEL, 8'h0C);
		wr(fcr_pkg::A_SLCFG, 8'h9D);
		rd(fcr_pkg::A_SLCFG, 8'h9D);
		$display("test_regs done");
	endtask

	task automatic test_paths;
		// Two frames to settle the swap, then watch one whole frame
		repeat (2 * FRAME) @(posedge i_clk);
		clr <= 1'b1;
		@(posedge i_clk);
		clr <= 1'b0;
		repeat (FRAME) @(posedge i_clk);
		@(negedge i_clk);
		chk(u_fcr_far_model.req_cnt, 1);
		chk(u_fcr_far_model.rx_cnt, 1);
		chk(32'(u_fcr_far_model.rx_id), 32'h13);
		chk(32'(u_fcr_far_model.rx_data), 32'h3A);
		chk(32'(l_tx[2]), 32'hA3);
		chk(32'(l_en[2]), 32'h1);
		chk(32'(l_en[0]), 32'h0);
		chk(ev_cnt, 0);
		chk(u_fcr_far_model.two_cnt, 976);
		chk(u_fcr_far_model.one_cnt, 976);
		chk(32'(u_fcr_far_model.two_data), 32'h69);
		chk(32'(u_fcr_far_model.one_data), 32'h69);
		$display("test_paths done");
	endtask

	initial begin
		repeat (99000) @(posedge i_clk);
		fail_count++;
		complete_run;
	end

	initial begin
		fail_count = 0;
		n_tests = 0;
		i_resetn = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		clr = 1'b1;
		repeat (12) @(posedge i_clk);
		i_resetn <= 1'b1;
		clr <= 1'b0;
		test_regs;
		test_paths;
		complete_run;
	end
endmodule
